// ==== src/spm_device.sv ====
// device end of the serial programming link: command shifter, table pointer,
// address decode of the 22-bit table space and read protection.
// assumes nonvolatile arrays outside answer memRdData combinationally
// within half a link clock; all logic here runs on the link clock.
//
// The APB register port was decided locally.
`timescale 1ns/1ns
module spm_device
	import spm_pkg::*;
#(
	parameter logic [15:0] DEVICE_ID_CODE = 16'h5a5a  // arbitrary value
)
(
	spm_link_if.device        link,
	input  wire logic         ce,
	input  wire logic         rst,
	input  wire logic         lowVoltageEnableBit,
	input  wire logic [4:0]   codeProtect,
	input  wire logic [7:0]   memRdData,
	output logic [21:0]       memRdAddr,
	output logic [21:0]       memWrAddr,
	output logic [7:0]        memWrData,
	output logic              memWrite,
	output logic              memWrStart,
	output logic              inCodeSpace,
	output logic              inBootRegion,
	output logic [1:0]        protBlock,
	output logic [2:0]        codePanel,
	output logic              progModeActive,
	output logic              ioHighZ,
	output logic              coreHalted
);

	logic        modeActive;            // program/verify mode level
	logic [4:0]  bitCnt_q, bitCnt_d;    // bits latched in this instruction
	logic [19:0] shift_q, shift_d;      // serial shifter, lsb first
	logic [3:0]  cmd_q, cmd_d;          // current four-bit command
	logic [21:0] ptr_q, ptr_d;          // table pointer
	logic [7:0]  wreg_q, wreg_d;        // working byte for core moves
	logic [7:0]  tabLatch_q, tabLatch_d;// byte shifted out to the programmer
	logic [21:0] wrAddr_q, wrAddr_d;    // write target
	logic [7:0]  wrData_q, wrData_d;    // write byte
	logic        wrEn_q, wrEn_d;        // write strobe
	logic        wrStart_q, wrStart_d;  // start programming strobe
	logic        outBit_q, outBit_d;    // data pin drive value
	logic        outOe_q, outOe_d;      // data pin enable
	logic [19:0] word;                  // shifter including the bit now latched
	logic [15:0] operand;               // operand of a finished instruction
	logic [7:0]  readVal;               // byte a table read returns
	logic        isRead;                // command shifts data out
	logic        inCode;
	logic        inBoot;
	logic        inId;
	logic        inCfg;
	logic        inDevId;
	logic [2:0]  protIdx;               // 0 boot, 1..4 regular blocks
	logic        codeLocked;

	// high voltage always enters; low-voltage pin only with the enable bit
	assign modeActive = link.programVoltagePin
		| (lowVoltageEnableBit & link.lowVoltageEntryPin);

	// in mode the core stays halted and pins float
	assign progModeActive = modeActive;
	assign coreHalted     = modeActive;
	assign ioHighZ        = modeActive;

	// address decode of the pointer
	always_comb
	begin
		inCode     = ptr_q <= CODE_TOP;
		inBoot     = ptr_q <= BOOT_TOP;
		inId       = ptr_q >= ID_BASE && ptr_q <= ID_TOP;
		inCfg      = ptr_q >= CFG_BASE && ptr_q <= CFG_TOP;
		inDevId    = ptr_q >= DEVID_BASE;
		// boot region carries its own protection bit ahead of block 1
		if (inBoot)
		begin
			protIdx = 3'h0;
		end
		else
		begin
			protIdx = {1'b0, ptr_q[CODE_MSB:BLOCK_LSB]} + 3'h1;
		end
		codeLocked = inCode && codeProtect[protIdx];
	end

	// value a table read sees; protection hides code bytes only
	always_comb
	begin
		if (inCode)
		begin
			readVal = codeLocked ? 8'h00 : memRdData;
		end
		else if (inId || inCfg)
		begin
			readVal = memRdData;
		end
		else if (inDevId)
		begin
			readVal = ptr_q[0] ? DEVICE_ID_CODE[15:8] : DEVICE_ID_CODE[7:0];
		end
		else
		begin
			readVal = 8'h00; // unmapped space reads zero
		end
	end

	assign memRdAddr    = ptr_q;
	assign inCodeSpace  = inCode;
	assign inBootRegion = inBoot;
	assign protBlock    = ptr_q[CODE_MSB:BLOCK_LSB];
	assign codePanel    = ptr_q[CODE_MSB:PANEL_LSB];
	assign memWrAddr    = wrAddr_q;
	assign memWrData    = wrData_q;
	assign memWrite     = wrEn_q;
	assign memWrStart   = wrStart_q;

	// next state of the falling-edge group: shift, decode, execute
	always_comb
	begin
		shift_d    = shift_q;
		bitCnt_d   = bitCnt_q;
		cmd_d      = cmd_q;
		ptr_d      = ptr_q;
		wreg_d     = wreg_q;
		tabLatch_d = tabLatch_q;
		wrAddr_d   = wrAddr_q;
		wrData_d   = wrData_q;
		wrEn_d     = 1'b0;
		wrStart_d  = 1'b0;
		// bits arrive lsb first, so each enters at the top
		word       = {link.progSerialData, shift_q[19:1]};
		operand    = word[19:4];
		shift_d    = word;
		bitCnt_d   = (bitCnt_q == INSTR_LAST) ? 5'h00 : bitCnt_q + 5'h01;
		// fourth bit completes the command
		if (bitCnt_q == CMD_LAST_BIT)
		begin
			cmd_d = word[19:16];
			if (word[19:16] == CMD_RD_PREINC)
			begin
				ptr_d = ptr_q + 22'h000001;
			end
		end
		// table reads fetch once the pointer has settled
		if (bitCnt_q == CMD_BITS)
		begin
			unique case (cmd_q)
				CMD_RD, CMD_RD_PREINC:
				begin
					tabLatch_d = readVal;
				end
				CMD_RD_POSTINC:
				begin
					tabLatch_d = readVal;
					ptr_d      = ptr_q + 22'h000001;
				end
				CMD_RD_POSTDEC:
				begin
					tabLatch_d = readVal;
					ptr_d      = ptr_q - 22'h000001;
				end
				default:
				begin
					// other commands act at the end of the operand
				end
			endcase
		end
		// last operand bit: execute
		if (bitCnt_q == INSTR_LAST)
		begin
			unique case (cmd_q)
				CMD_CORE:
				begin
					// only literal and register moves matter to the pointer
					if (operand[15:8] == OP_MOVLW)
					begin
						wreg_d = operand[7:0];
					end
					else if (operand[15:8] == OP_MOVWF)
					begin
						if ({ACCESS_BANK_HI, operand[7:0]} == PTR_UPPER_ADDR)
						begin
							ptr_d = {wreg_q[5:0], ptr_q[15:0]};
						end
						else if ({ACCESS_BANK_HI, operand[7:0]} == PTR_HIGH_ADDR)
						begin
							ptr_d = {ptr_q[21:16], wreg_q, ptr_q[7:0]};
						end
						else if ({ACCESS_BANK_HI, operand[7:0]} == PTR_LOW_ADDR)
						begin
							ptr_d = {ptr_q[21:8], wreg_q};
						end
					end
				end
				CMD_WR, CMD_WR_POSTINC2, CMD_WR_POSTDEC2, CMD_WR_START:
				begin
					// the part id is read-only, so writes there are dropped
					wrEn_d    = !inDevId;
					wrStart_d = cmd_q == CMD_WR_START;
					wrAddr_d  = ptr_q;
					wrData_d  = operand[7:0];
					if (cmd_q == CMD_WR_POSTINC2)
					begin
						ptr_d = ptr_q + 22'h000002;
					end
					else if (cmd_q == CMD_WR_POSTDEC2)
					begin
						ptr_d = ptr_q - 22'h000002;
					end
				end
				default:
				begin
					// read commands finished their work earlier
				end
			endcase
		end
	end

	// falling-edge registers; leaving mode clears the frame at once,
	// since the link clock is held low around entry
	always_ff @(negedge link.progSerialClock or negedge modeActive)
	begin
		if (!modeActive)
		begin
			shift_q    <= 20'h00000;
			bitCnt_q   <= 5'h00;
			cmd_q      <= CMD_CORE;
			ptr_q      <= PTR_RESET;
			wreg_q     <= 8'h00;
			tabLatch_q <= 8'h00;
			wrAddr_q   <= PTR_RESET;
			wrData_q   <= 8'h00;
			wrEn_q     <= 1'b0;
			wrStart_q  <= 1'b0;
		end
		else if (rst)
		begin
			shift_q    <= 20'h00000;
			bitCnt_q   <= 5'h00;
			cmd_q      <= CMD_CORE;
			ptr_q      <= PTR_RESET;
			wreg_q     <= 8'h00;
			tabLatch_q <= 8'h00;
			wrAddr_q   <= PTR_RESET;
			wrData_q   <= 8'h00;
			wrEn_q     <= 1'b0;
			wrStart_q  <= 1'b0;
		end
		else if (ce)
		begin
			shift_q    <= shift_d;
			bitCnt_q   <= bitCnt_d;
			cmd_q      <= cmd_d;
			ptr_q      <= ptr_d;
			wreg_q     <= wreg_d;
			tabLatch_q <= tabLatch_d;
			wrAddr_q   <= wrAddr_d;
			wrData_q   <= wrData_d;
			wrEn_q     <= wrEn_d;
			wrStart_q  <= wrStart_d;
		end
	end

	// data out is presented on the rising edge of the last eight bits
	always_comb
	begin
		isRead   = cmd_q == CMD_SHIFT_OUT || cmd_q[3:2] == CMD_RD[3:2];
		outOe_d  = isRead && bitCnt_q >= OUT_FIRST_BIT;
		outBit_d = tabLatch_q[3'(bitCnt_q - OUT_FIRST_BIT)];
	end

	// rising-edge output registers
	always_ff @(posedge link.progSerialClock or negedge modeActive)
	begin
		if (!modeActive)
		begin
			outBit_q <= 1'b0;
			outOe_q  <= 1'b0;
		end
		else if (rst)
		begin
			outBit_q <= 1'b0;
			outOe_q  <= 1'b0;
		end
		else if (ce)
		begin
			outBit_q <= outBit_d;
			outOe_q  <= outOe_d;
		end
	end

	assign link.devDataOut = outBit_q;
	assign link.devDataOe  = outOe_q;

endmodule : spm_device

// ==== include/spm_pkg.sv ====
// constants shared by the serial programming link: address map, commands,
// programmer register offsets and link timing.
// assumes both link ends and the bench import it whole.
//
// Overview of operation
// - code memory 0 to 0FFFFh, four 16K blocks
// - 0000h to 07FFh boot region protected separately
// - code panels fall on 8K boundaries
// - eight id bytes at 200000h to 200007h
// - id bytes read normally under code protection
// - configuration bytes 300000h to 30000Dh, always readable
// - part id at top two addresses, always readable
// - pointer bytes form 22-bit address
// - pointer bytes at 0FF8h, 0FF7h, 0FF6h
// - programmer loads pointer with core instructions
// - clock, data low, then raise programming voltage
// - mode gives serial access to all memories
// - unused pins go high impedance in mode
// - erase, program, verify, configuration bits last
// - oscillator input held high while programming
// - low-voltage entry only when enable bit set
// - present on rising, latch on falling, lsb first
// - instruction is 4-bit command plus 16-bit operand
package spm_pkg;

	// memory map of the 22-bit table space
	localparam logic [21:0] CODE_TOP   = 22'h00ffff;
	localparam logic [21:0] BOOT_TOP   = 22'h0007ff;
	localparam logic [21:0] ID_BASE    = 22'h200000;
	localparam logic [21:0] ID_TOP     = 22'h200007;
	localparam logic [21:0] CFG_BASE   = 22'h300000;
	localparam logic [21:0] CFG_TOP    = 22'h30000d;
	localparam logic [21:0] DEVID_BASE = 22'h3ffffe;
	localparam logic [21:0] PTR_RESET  = 22'h000000;
	localparam int          BLOCK_LSB  = 14;
	localparam int          PANEL_LSB  = 13;
	localparam int          CODE_MSB   = 15;

	// register file addresses of the pointer bytes
	localparam logic [11:0] PTR_LOW_ADDR   = 12'hff6;
	localparam logic [11:0] PTR_HIGH_ADDR  = 12'hff7;
	localparam logic [11:0] PTR_UPPER_ADDR = 12'hff8;
	localparam logic [3:0]  ACCESS_BANK_HI = 4'hf;

	// serial framing
	localparam logic [4:0] CMD_LAST_BIT  = 5'h03;
	localparam logic [4:0] CMD_BITS      = 5'h04;
	localparam logic [4:0] OUT_FIRST_BIT = 5'h0c;
	localparam logic [4:0] INSTR_LAST    = 5'h13;

	// four-bit commands
	localparam logic [3:0] CMD_CORE        = 4'h0;
	localparam logic [3:0] CMD_SHIFT_OUT   = 4'h2;
	localparam logic [3:0] CMD_RD          = 4'h8;
	localparam logic [3:0] CMD_RD_POSTINC  = 4'h9;
	localparam logic [3:0] CMD_RD_POSTDEC  = 4'ha;
	localparam logic [3:0] CMD_RD_PREINC   = 4'hb;
	localparam logic [3:0] CMD_WR          = 4'hc;
	localparam logic [3:0] CMD_WR_POSTINC2 = 4'hd;
	localparam logic [3:0] CMD_WR_POSTDEC2 = 4'he;
	localparam logic [3:0] CMD_WR_START    = 4'hf;

	// core opcodes understood by the pointer loader
	localparam logic [7:0] OP_MOVLW = 8'h0e;
	localparam logic [7:0] OP_MOVWF = 8'h6e;

	// programmer register offsets and fields
	localparam logic [11:0] REG_CTRL      = 12'h000;
	localparam logic [11:0] REG_CMD       = 12'h004;
	localparam logic [11:0] REG_STATUS    = 12'h008;
	localparam logic [11:0] REG_RDATA     = 12'h00c;
	localparam int          CTRL_ENTER    = 0;
	localparam int          STATUS_BUSY   = 0;
	localparam int          STATUS_MODE   = 1;
	localparam int          CMD_OPC_LSB   = 16;

	// link timing made by the programmer
	localparam int         SYS_PERIOD_NS  = 10;
	localparam int         LINK_PERIOD_NS = 125;
	localparam int         ENTRY_HOLD_NS  = 100;
	localparam logic [7:0] LINK_HALF_CYC  =
		8'((LINK_PERIOD_NS + 2 * SYS_PERIOD_NS - 1) / (2 * SYS_PERIOD_NS));
	localparam logic [7:0] ENTRY_CYC      =
		8'((ENTRY_HOLD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

endpackage : spm_pkg

// ==== include/spm_link_if.sv ====
// pins between the external programmer and the device under programming.
// assumes the bench ties the two ends together through this interface only.
`timescale 1ns/1ns
interface spm_link_if;
	logic progSerialClock;     // serial clock, made by the programmer
	logic hostDataOut;         // programmer drive value on the data pin
	logic hostDataOe;          // programmer drives the data pin
	logic devDataOut;          // device drive value on the data pin
	logic devDataOe;           // device drives the data pin
	logic progSerialData;      // resolved data pin level
	logic programVoltagePin;   // high means raised to the high entry level
	logic lowVoltageEntryPin;  // low-voltage entry request
	logic oscillatorInputPin;  // oscillator input, held high in mode

	// device wins while it answers; an undriven pin reads low (pull-down)
	assign progSerialData = devDataOe ? devDataOut : (hostDataOe ? hostDataOut : 1'b0);

	modport device (
		input  progSerialClock,
		input  progSerialData,
		input  programVoltagePin,
		input  lowVoltageEntryPin,
		input  oscillatorInputPin,
		output devDataOut,
		output devDataOe
	);

	modport programmer (
		output progSerialClock,
		output hostDataOut,
		output hostDataOe,
		output programVoltagePin,
		output lowVoltageEntryPin,
		output oscillatorInputPin,
		input  progSerialData
	);
endinterface : spm_link_if

// ==== src/spm_programmer.sv ====
// programmer end: APB register slave, mode entry sequencer and
// serial shifter that makes the link clock from the system clock.
// assumes software orders the steps (pointer load, erase, program,
// verify, configuration last) through the command register.
`timescale 1ns/1ns
module spm_programmer
	import spm_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	spm_link_if.programmer    link
);

	typedef enum logic [2:0] {P_OFF, P_SETUP, P_IDLE, P_HIGH, P_LOW} spm_state_t;

	spm_state_t  state_q, state_d;     // sequencer state
	logic [7:0]  cnt_q, cnt_d;         // cycles within a phase
	logic [4:0]  bit_q, bit_d;         // instruction bit on the pin
	logic [19:0] instr_q, instr_d;     // stream, command first, lsb first
	logic [7:0]  rx_q, rx_d;           // bits gathered from the device
	logic [7:0]  rdata_q, rdata_d;     // last byte read, software view
	logic        enter_q, enter_d;     // software asks for the mode
	logic        sclk_q, sclk_d;       // link clock out
	logic        dat_q, dat_d;         // data pin drive value
	logic        oe_q, oe_d;           // data pin enable
	logic        vpp_q, vpp_d;         // programming voltage raised
	logic [31:0] prdata_q, prdata_d;   // read data held for the access phase
	logic        syncA_q;              // first stage, read by syncB only
	logic        syncB_q;              // data pin in the system domain
	logic        access;
	logic        cmdWrite;
	logic        cmdStall;
	logic        cmdGo;
	logic        mapped;
	logic        readCmd;

	// bus decode; a command waits in the access phase while a shift runs
	always_comb
	begin
		access   = psel && penable;
		cmdWrite = access && pwrite && paddr == REG_CMD;
		cmdStall = cmdWrite && (state_q == P_SETUP || state_q == P_HIGH || state_q == P_LOW);
		pready   = ce && !cmdStall;
		mapped   = paddr == REG_CTRL || paddr == REG_CMD || paddr == REG_STATUS
			|| paddr == REG_RDATA;
		// a command with no mode entered is refused rather than lost
		pslverr  = access && pready && (!mapped || (cmdWrite && state_q == P_OFF));
		cmdGo    = cmdWrite && pready && state_q == P_IDLE;
		readCmd  = instr_q[3:0] == CMD_SHIFT_OUT || instr_q[3:2] == CMD_RD[3:2];
	end

	// next values of registers and the serial sequencer
	always_comb
	begin
		state_d  = state_q;
		cnt_d    = cnt_q + 8'h01;
		bit_d    = bit_q;
		instr_d  = instr_q;
		rx_d     = rx_q;
		rdata_d  = rdata_q;
		enter_d  = enter_q;
		sclk_d   = sclk_q;
		dat_d    = dat_q;
		oe_d     = oe_q;
		vpp_d    = vpp_q;
		prdata_d = prdata_q;
		// read data is sampled in the setup cycle
		if (psel && !penable && !pwrite)
		begin
			prdata_d = 32'h00000000;
			if (paddr == REG_CTRL)
			begin
				prdata_d[CTRL_ENTER] = enter_q;
			end
			else if (paddr == REG_STATUS)
			begin
				prdata_d[STATUS_BUSY] = state_q != P_IDLE && state_q != P_OFF;
				prdata_d[STATUS_MODE] = vpp_q;
			end
			else if (paddr == REG_RDATA)
			begin
				prdata_d[7:0] = rdata_q;
			end
		end
		if (access && pwrite && pready && paddr == REG_CTRL)
		begin
			enter_d = pwdata[CTRL_ENTER];
		end
		unique case (state_q)
			P_OFF:
			begin
				// clock and data low before any voltage is raised
				sclk_d = 1'b0;
				dat_d  = 1'b0;
				oe_d   = 1'b1;
				vpp_d  = 1'b0;
				cnt_d  = 8'h00;
				if (enter_q)
				begin
					state_d = P_SETUP;
				end
			end
			P_SETUP:
			begin
				if (cnt_q == ENTRY_CYC - 8'h01)
				begin
					vpp_d   = 1'b1;
					cnt_d   = 8'h00;
					state_d = P_IDLE;
				end
			end
			P_IDLE:
			begin
				cnt_d = 8'h00;
				if (!enter_q)
				begin
					vpp_d   = 1'b0;
					state_d = P_OFF;
				end
				else if (cmdGo)
				begin
					// stream order: command bits then operand, each lsb first
					instr_d = {pwdata[15:0], pwdata[CMD_OPC_LSB +: 4]};
					bit_d   = 5'h00;
					sclk_d  = 1'b1;
					dat_d   = pwdata[CMD_OPC_LSB];
					oe_d    = 1'b1;
					state_d = P_HIGH;
				end
			end
			P_HIGH:
			begin
				if (cnt_q == LINK_HALF_CYC - 8'h01)
				begin
					sclk_d = 1'b0;
					if (readCmd && bit_q >= OUT_FIRST_BIT)
					begin
						rx_d[3'(bit_q - OUT_FIRST_BIT)] = syncB_q;
					end
					cnt_d   = 8'h00;
					state_d = P_LOW;
				end
			end
			P_LOW:
			begin
				if (cnt_q == LINK_HALF_CYC - 8'h01)
				begin
					cnt_d = 8'h00;
					if (bit_q == INSTR_LAST)
					begin
						dat_d   = 1'b0;
						// stay off the pin while the device still shows its last bit
						oe_d    = !readCmd;
						rdata_d = readCmd ? rx_q : rdata_q;
						state_d = P_IDLE;
					end
					else
					begin
						bit_d   = bit_q + 5'h01;
						sclk_d  = 1'b1;
						// release the pin while the device answers
						oe_d    = !(readCmd && bit_q + 5'h01 >= OUT_FIRST_BIT);
						dat_d   = instr_q[bit_q + 5'h01];
						state_d = P_HIGH;
					end
				end
			end
		endcase
	end

	// registers of the programmer; only reset moves them while ce is low
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_q  <= P_OFF;
			cnt_q    <= 8'h00;
			bit_q    <= 5'h00;
			instr_q  <= 20'h00000;
			rx_q     <= 8'h00;
			rdata_q  <= 8'h00;
			enter_q  <= 1'b0;
			sclk_q   <= 1'b0;
			dat_q    <= 1'b0;
			oe_q     <= 1'b1;
			vpp_q    <= 1'b0;
			prdata_q <= 32'h00000000;
			syncA_q  <= 1'b0;
			syncB_q  <= 1'b0;
		end
		else if (ce)
		begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			bit_q    <= bit_d;
			instr_q  <= instr_d;
			rx_q     <= rx_d;
			rdata_q  <= rdata_d;
			enter_q  <= enter_d;
			sclk_q   <= sclk_d;
			dat_q    <= dat_d;
			oe_q     <= oe_d;
			vpp_q    <= vpp_d;
			prdata_q <= prdata_d;
			syncA_q  <= link.progSerialData;
			syncB_q  <= syncA_q;
		end
	end

	assign prdata                  = prdata_q;
	assign link.progSerialClock    = sclk_q;
	assign link.hostDataOut        = dat_q;
	assign link.hostDataOe         = oe_q;
	assign link.programVoltagePin  = vpp_q;
	assign link.lowVoltageEntryPin = 1'b0;
	assign link.oscillatorInputPin = vpp_q;

endmodule : spm_programmer

// ==== testbench/spm_link_assertions.sv ====
// checker for the programming link pins, sampled on the system clock.
// assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ns
module spm_link_assertions (
	input wire logic clock,
	input wire logic rst,
	input wire logic progSerialClock,
	input wire logic progSerialData,
	input wire logic devDataOe,
	input wire logic programVoltagePin,
	input wire logic lowVoltageEntryPin,
	input wire logic oscillatorInputPin
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	logic       clkPrev_q;  // link clock one cycle ago
	logic [7:0] lowRun_q;   // low samples since the clock was last high
	logic [7:0] lowRun_d;
	logic [4:0] bits_q;     // rising edges seen in the current frame
	logic [4:0] bits_d;
	logic       riseNow;    // link clock rises in this cycle

	// a long low spell marks a frame boundary; short gaps go unseen
	always_comb
	begin
		riseNow  = progSerialClock && !clkPrev_q;
		lowRun_d = lowRun_q;
		if (progSerialClock)
			lowRun_d = 8'h00;
		else if (lowRun_q != 8'hff)
			lowRun_d = lowRun_q + 8'h01;
		bits_d = bits_q;
		if (riseNow)
			bits_d = (lowRun_q > 8'h07) ? 5'h01 : bits_q + 5'h01;
	end

	// registers only
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			clkPrev_q <= 1'b0;
			lowRun_q  <= 8'h00;
			bits_q    <= 5'h00;
		end
		else
		begin
			clkPrev_q <= progSerialClock;
			lowRun_q  <= lowRun_d;
			bits_q    <= bits_d;
		end
	end

	chk_entry_pins_low: assert property ($rose(programVoltagePin) |-> !progSerialClock && !progSerialData)
		else $error("link clock or data high when voltage rose");
	chk_clock_idle_off: assert property (!programVoltagePin |-> !progSerialClock)
		else $error("link clock runs outside the mode");
	chk_osc_held_high: assert property (programVoltagePin |-> oscillatorInputPin)
		else $error("oscillator input low in the mode");
	chk_low_entry_unused: assert property (!lowVoltageEntryPin)
		else $error("low-voltage entry pin raised");
	chk_high_half_len: assert property ($rose(progSerialClock) |-> progSerialClock[*7] ##1 !progSerialClock)
		else $error("link clock high phase not seven cycles");
	chk_data_steady_high: assert property (progSerialClock && $past(progSerialClock) |-> $stable(progSerialData))
		else $error("data pin moved while link clock high");
	chk_release_off_mode: assert property (!programVoltagePin |-> !devDataOe)
		else $error("device drives data outside the mode");
	chk_frame_twenty_bits: assert property (riseNow && lowRun_q > 8'h07 |-> bits_q == 5'h00 || bits_q == 5'h14)
		else $error("frame without twenty clock pulses");

	cov_mode_entry: cover property ($rose(programVoltagePin));
	cov_device_answer: cover property ($rose(devDataOe));
	cov_full_frame: cover property (riseNow && lowRun_q > 8'h07 && bits_q == 5'h14);
endmodule : spm_link_assertions

// ==== testbench/tb_serial_program_mode_memory_map.sv ====
// bench: programmer and device joined by the link, orders given over APB.
// assumes an array model that answers device reads combinationally.
`timescale 1ns/1ns
module tb_serial_program_mode_memory_map
	import spm_pkg::*;
;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat;
	logic        pready, pslverr, rerr;
	logic        lowVoltageEnableBit = 1'b0;
	logic [4:0]  codeProtect = 5'h00;
	logic [7:0]  memRdData, memWrData, wrData;
	logic [21:0] memRdAddr, memWrAddr, wrAddr;
	logic        memWrite, memWrStart, inCodeSpace, inBootRegion;
	logic [1:0]  protBlock;
	logic [2:0]  codePanel;
	logic        progModeActive, ioHighZ, coreHalted;
	int          fails = 0, totalChecks = 0, wrHits = 0, startHits = 0;

	always #5 clock = ~clock;
	// array model: a cheap pattern that differs per low address byte
	assign memRdData = memRdAddr[7:0] ^ 8'h3c;

	spm_link_if link ();
	spm_programmer u_spm_programmer (.clock, .rst, .ce(1'b1), .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .link(link));
	spm_device #(.DEVICE_ID_CODE(16'h1234)) u_spm_device (.link(link), .ce(1'b1), .rst,  // arbitrary id
		.lowVoltageEnableBit, .codeProtect, .memRdData, .memRdAddr, .memWrAddr, .memWrData,
		.memWrite, .memWrStart, .inCodeSpace, .inBootRegion, .protBlock, .codePanel,
		.progModeActive, .ioHighZ, .coreHalted);
	spm_link_assertions u_spm_link_assertions (.clock, .rst,
		.progSerialClock(link.progSerialClock), .progSerialData(link.progSerialData),
		.devDataOe(link.devDataOe), .programVoltagePin(link.programVoltagePin),
		.lowVoltageEntryPin(link.lowVoltageEntryPin), .oscillatorInputPin(link.oscillatorInputPin));

	// capture store pulses once the registered outputs have landed
	always @(posedge memWrite)
	begin
		#1;
		wrHits++;
		wrAddr = memWrAddr;
		wrData = memWrData;
	end
	always @(posedge memWrStart)
		startHits++;

	function automatic logic [7:0] mem(input logic [21:0] a);
		return a[7:0] ^ 8'h3c;
	endfunction : mem

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one APB transfer; waits for pready however long it takes
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one instruction, then wait for busy to clear and leave a long gap
	task automatic cmd(input logic [19:0] w);
		apb(1'b1, REG_CMD, {12'h000, w});
		do
			apb(1'b0, REG_STATUS, 32'h0);
		while (rdat[STATUS_BUSY] !== 1'b0);
		repeat (10) @(posedge clock);
	endtask : cmd

	// pointer load with core words, upper byte first
	task automatic xfer(input logic [3:0] c, input logic [21:0] a, input logic [7:0] exp,
		input logic [21:0] ptr);
		logic [7:0] v [3];
		int         hits;
		v = '{{2'b00, a[21:16]}, a[15:8], a[7:0]};
		for (int i = 0; i < 3; i++)
		begin
			cmd({CMD_CORE, OP_MOVLW, v[i]});
			cmd({CMD_CORE, OP_MOVWF, PTR_UPPER_ADDR[7:0] - 8'(i)});
		end
		check("pointer", memRdAddr, a);
		check("code", inCodeSpace, a <= 22'h00ffff);
		check("boot", inBootRegion, a <= 22'h0007ff);
		if (a <= 22'h00ffff)
		begin
			check("block", protBlock, a[15:14]);
			check("panel", codePanel, a[15:13]);
		end
		hits = wrHits;
		cmd({c, 16'h00a5});
		if (c[3:2] == 2'b11)
		begin
			check("stored", wrHits - hits, a < 22'h3ffffe);
			if (a < 22'h3ffffe)
				check("store", {wrAddr, wrData}, {a, 8'ha5});
		end
		else
		begin
			apb(1'b0, REG_RDATA, 32'h0);
			check("rdata", rdat, exp);
		end
		check("after", memRdAddr, ptr);
	endtask : xfer

	task automatic testDone();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : testDone

	// watchdog, far above the expected run of some 32k cycles
	initial
	begin
		#1000000;
		fails++;
		testDone();
	end

	initial
	begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		lowVoltageEnableBit <= 1'b1;
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped err", rerr, 1'b1);
		check("unmapped", rdat, 32'h0);
		apb(1'b1, REG_CMD, 32'h0);
		check("cmd off", rerr, 1'b1);
		check("mode off", progModeActive, 1'b0);
		apb(1'b1, REG_CTRL, 32'h1);
		repeat (20) @(posedge clock);
		apb(1'b0, REG_STATUS, 32'h0);
		check("raised", rdat, 32'h2);
		check("mode on", {progModeActive, ioHighZ, coreHalted}, 3'h7);
		codeProtect <= 5'h1f;
		xfer(CMD_RD, 22'h200003, mem(22'h200003), 22'h200003);
		xfer(CMD_SHIFT_OUT, 22'h200007, mem(22'h200003), 22'h200007);
		xfer(CMD_RD, 22'h30000d, mem(22'h30000d), 22'h30000d);
		xfer(CMD_RD, 22'h3ffffe, 8'h34, 22'h3ffffe);
		xfer(CMD_RD, 22'h3fffff, 8'h12, 22'h3fffff);
		xfer(CMD_RD, 22'h004000, 8'h00, 22'h004000);
		codeProtect <= 5'h02;
		xfer(CMD_RD_POSTINC, 22'h0007ff, mem(22'h0007ff), 22'h000800);
		xfer(CMD_RD_POSTDEC, 22'h000800, 8'h00, 22'h0007ff);
		xfer(CMD_RD_PREINC, 22'h00dfff, mem(22'h00e000), 22'h00e000);
		xfer(CMD_WR, 22'h002000, 8'h00, 22'h002000);
		xfer(CMD_WR_POSTINC2, 22'h00fffe, 8'h00, 22'h010000);
		xfer(CMD_WR_POSTDEC2, 22'h200000, 8'h00, 22'h1ffffe);
		xfer(CMD_WR_START, 22'h200001, 8'h00, 22'h200001);
		check("start", startHits, 1);
		xfer(CMD_WR, 22'h3ffffe, 8'h00, 22'h3ffffe);
		// configuration bytes only after everything else is in and verified
		xfer(CMD_WR, 22'h300000, 8'h00, 22'h300000);
		apb(1'b1, REG_CTRL, 32'h0);
		repeat (20) @(posedge clock);
		check("left", progModeActive, 1'b0);
		testDone();
	end
endmodule : tb_serial_program_mode_memory_map
